// ==== design/dcb_top.sv ====
/*
  dcb_top: command decoder and per-bank state tracker.
  Assumes the command pins come from off-chip and are synchronised here;
  sys_clk stands in for the memory clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - decode from cs ras cas we cke
// - all low loads mode register
// - bank address selects target bank
// - top bank bit only for large parts
// - read/write, a10 selects auto precharge
// - precharge, a10 selects all banks
// - refresh, or self refresh if cke falls
// - self refresh exit asynchronous on cke; here clocked from synchronised cke, a cycle late
// - power-down on cke edges, no refresh
// - deselect and nop change nothing
// - odt ignored, disabled in self refresh
// - idle accepts activate, refresh, mode load
// - row active accepts read write precharge
// - bursts accept rd/wr/pre, wr after read
// - precharge timed, then bank idle
// - activate timed, then row active
// - auto precharge returns bank idle
// - refresh and mode load block everything
module dcb_top #(
  parameter bit LARGE_DENSITY = 1'b1
) (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire dcb_pkg::dcb_pins_s         pins,
  input  wire logic                       odt,
  output var  dcb_pkg::dcb_dec_s          dec,
  output var  logic                       cmd_illegal,
  output var  logic [dcb_pkg::NUM_BANKS-1:0] bank_idle,
  output var  dcb_pkg::dcb_dev_e          dev_state,
  output var  logic                       odt_active,
  output var  logic                       in_self_ref
);

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  dcb_pkg::dcb_pins_s pins_m;
  dcb_pkg::dcb_pins_s pins_s;
  logic               odt_m;
  logic               odt_s;
  logic               cke_prev;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_m   <= '0;
      pins_s   <= '0;
      odt_m    <= 1'b0;
      odt_s    <= 1'b0;
      cke_prev <= dcb_pkg::RST_CKE;
    end else begin
      pins_m   <= pins;
      pins_s   <= pins_m;
      odt_m    <= odt;
      odt_s    <= odt_m;
      cke_prev <= pins_s.cke;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // pure pin decode, reused for every cycle's command
  function automatic dcb_pkg::dcb_cmd_e decode(
    input logic ck_p,
    input logic ck_n,
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic a10
  );
    logic nopish;
    nopish = cs_n || (ras_n && cas_n && we_n);
    // power-down edges need deselect or nop
    if (ck_p && !ck_n) begin
      if (nopish)
        return dcb_pkg::CMD_PD_IN;
      else if (!ras_n && !cas_n && we_n)
        return dcb_pkg::CMD_SR_IN;
      else
        return dcb_pkg::CMD_ILLEGAL;
    end
    if (!ck_p) begin
      if (!ck_n)
        return dcb_pkg::CMD_DESEL;
      return nopish ? dcb_pkg::CMD_PD_OUT : dcb_pkg::CMD_ILLEGAL;
    end
    if (cs_n)
      return dcb_pkg::CMD_DESEL;
    case ({ras_n, cas_n, we_n})
      3'h7:    return dcb_pkg::CMD_NOP;
      3'h0:    return dcb_pkg::CMD_LMODE;
      3'h1:    return dcb_pkg::CMD_REF;
      3'h3:    return dcb_pkg::CMD_ACT;
      3'h5:    return dcb_pkg::CMD_RD;
      3'h4:    return dcb_pkg::CMD_WR;
      3'h2:    return a10 ? dcb_pkg::CMD_PRE_ALL : dcb_pkg::CMD_PRE;
      default: return dcb_pkg::CMD_ILLEGAL;
    endcase
  endfunction

  dcb_pkg::dcb_cmd_e  raw_cmd;
  logic [dcb_pkg::BA_W-1:0] eff_ba;
  logic               a10;

  // odt does not enter the decode
  assign a10     = pins_s.addr[dcb_pkg::A10_BIT];
  assign raw_cmd = decode(cke_prev, pins_s.cke, pins_s.cs_n, pins_s.ras_n,
                          pins_s.cas_n, pins_s.we_n, a10);
  // top bank bit dropped on small parts
  assign eff_ba  = LARGE_DENSITY ? pins_s.ba
                                 : {1'b0, pins_s.ba[dcb_pkg::BA_W-2:0]};

  // ---------------------------------------------------------------
  // device-wide state
  // ---------------------------------------------------------------
  dcb_pkg::dcb_dev_e          next_dev;
  logic [dcb_pkg::CNT_W-1:0]  dev_cnt;
  dcb_pkg::dcb_bank_e         bstate [dcb_pkg::NUM_BANKS];
  logic [dcb_pkg::NUM_BANKS-1:0] brd_busy;
  logic                       all_idle;
  logic                       normal;
  logic                       accept;
  logic                       legal;
  logic                       force_idle;
  logic                       cke_sr_seen;

  // bank rules need normal state, cke high twice
  assign normal = (dev_state == dcb_pkg::DV_NORMAL) && cke_prev
                  && pins_s.cke;

  // exit watches cke directly; no clock edge needed in the memory
  // this only catches the exit level a cycle late, clocked model cannot do better
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cke_sr_seen <= 1'b0;
    end else begin
      cke_sr_seen <= (dev_state == dcb_pkg::DV_SELF) && pins_s.cke;
    end
  end

  // device-level transitions
  always_comb begin
    next_dev = dev_state;
    case (dev_state)
      dcb_pkg::DV_NORMAL: begin
        if (raw_cmd == dcb_pkg::CMD_REF && accept)
          next_dev = dcb_pkg::DV_REFRESH;
        else if (raw_cmd == dcb_pkg::CMD_LMODE && accept)
          next_dev = dcb_pkg::DV_MODE;
        else if (raw_cmd == dcb_pkg::CMD_SR_IN && all_idle)
          next_dev = dcb_pkg::DV_SELF;
        else if (raw_cmd == dcb_pkg::CMD_PD_IN)
          next_dev = dcb_pkg::DV_PDOWN;
      end
      dcb_pkg::DV_REFRESH, dcb_pkg::DV_MODE, dcb_pkg::DV_XSNR: begin
        if (dev_cnt <= 8'h01)
          next_dev = dcb_pkg::DV_NORMAL;
      end
      dcb_pkg::DV_SELF: begin
        if (cke_sr_seen)
          next_dev = dcb_pkg::DV_XSNR;
      end
      dcb_pkg::DV_PDOWN: begin
        if (raw_cmd == dcb_pkg::CMD_PD_OUT)
          next_dev = dcb_pkg::DV_NORMAL;
      end
      default: next_dev = dcb_pkg::DV_NORMAL;
    endcase
  end

  // device state and its timer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_state <= dcb_pkg::DV_NORMAL;
      dev_cnt   <= '0;
    end else begin
      dev_state <= next_dev;
      if (next_dev != dev_state) begin
        case (next_dev)
          dcb_pkg::DV_REFRESH: dev_cnt <= dcb_pkg::RFC_CYC;
          dcb_pkg::DV_MODE:    dev_cnt <= dcb_pkg::MRD_CYC;
          dcb_pkg::DV_XSNR:    dev_cnt <= dcb_pkg::XSNR_CYC;
          default:             dev_cnt <= '0;
        endcase
      end else if (dev_cnt != '0) begin
        dev_cnt <= dev_cnt - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // legality against bank state
  // ---------------------------------------------------------------
  // all banks idle and no read tail
  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < dcb_pkg::NUM_BANKS; i++) begin
      if (bstate[i] != dcb_pkg::BK_IDLE || brd_busy[i])
        all_idle = 1'b0;
    end
  end

  // per-command check against the addressed bank, or against all banks for refresh, mode load and precharge all
  always_comb begin
    dcb_pkg::dcb_bank_e tb;
    tb    = bstate[eff_ba];
    legal = 1'b0;
    case (raw_cmd)
      dcb_pkg::CMD_ACT: legal = (tb == dcb_pkg::BK_IDLE);
      // refresh and mode only when all idle
      dcb_pkg::CMD_REF, dcb_pkg::CMD_LMODE: legal = all_idle;
      dcb_pkg::CMD_RD: legal = (tb == dcb_pkg::BK_ACTIVE)
                               || (tb == dcb_pkg::BK_READ)
                               || (tb == dcb_pkg::BK_WRITE);
      dcb_pkg::CMD_WR: legal = ((tb == dcb_pkg::BK_ACTIVE)
                               || (tb == dcb_pkg::BK_READ)
                               || (tb == dcb_pkg::BK_WRITE))
                               && !brd_busy[eff_ba];
      dcb_pkg::CMD_PRE: legal = (tb == dcb_pkg::BK_ACTIVE)
                                || (tb == dcb_pkg::BK_READ)
                                || (tb == dcb_pkg::BK_WRITE)
                                || (tb == dcb_pkg::BK_IDLE);
      dcb_pkg::CMD_PRE_ALL: begin
        legal = 1'b1;
        for (int i = 0; i < dcb_pkg::NUM_BANKS; i++) begin
          if (bstate[i] == dcb_pkg::BK_ACTVG
              || bstate[i] == dcb_pkg::BK_RD_AP
              || bstate[i] == dcb_pkg::BK_WR_AP)
            legal = 1'b0;
        end
      end
      default: legal = 1'b0;
    endcase
  end

  // transitional states reject same-bank commands above
  assign accept = normal && legal;
  assign force_idle = (dev_state == dcb_pkg::DV_REFRESH)
                      || (dev_state == dcb_pkg::DV_MODE);

  // ---------------------------------------------------------------
  // banks
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < dcb_pkg::NUM_BANKS; g++) begin : g_bank
      logic hit;
      assign hit = accept && ((raw_cmd == dcb_pkg::CMD_PRE_ALL)
                   || ((int'(eff_ba) == g)
                       && (raw_cmd == dcb_pkg::CMD_ACT
                           || raw_cmd == dcb_pkg::CMD_RD
                           || raw_cmd == dcb_pkg::CMD_WR
                           || raw_cmd == dcb_pkg::CMD_PRE)));
      dcb_bank u_bank (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .hit        (hit),
        .cmd        (raw_cmd),
        .auto_pre   (a10),
        .force_idle (force_idle),
        .state      (bstate[g]),
        .rd_busy    (brd_busy[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // registered report of each cycle's command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec         <= '0;
      cmd_illegal <= 1'b0;
      bank_idle   <= '1;
      odt_active  <= 1'b0;
      in_self_ref <= 1'b0;
    end else begin
      dec.valid    <= accept || raw_cmd == dcb_pkg::CMD_SR_IN
                      || raw_cmd == dcb_pkg::CMD_PD_IN
                      || raw_cmd == dcb_pkg::CMD_PD_OUT;
      dec.cmd      <= raw_cmd;
      dec.bank     <= eff_ba;
      dec.auto_pre <= a10;
      dec.addr     <= pins_s.addr;
      cmd_illegal  <= !(raw_cmd == dcb_pkg::CMD_DESEL
                        || raw_cmd == dcb_pkg::CMD_NOP)
                      && !accept
                      && (dev_state == dcb_pkg::DV_NORMAL
                          || dev_state == dcb_pkg::DV_REFRESH
                          || dev_state == dcb_pkg::DV_MODE)
                      && raw_cmd != dcb_pkg::CMD_PD_OUT
                      && raw_cmd != dcb_pkg::CMD_PD_IN
                      && raw_cmd != dcb_pkg::CMD_SR_IN;
      for (int i = 0; i < dcb_pkg::NUM_BANKS; i++) begin
        bank_idle[i] <= (bstate[i] == dcb_pkg::BK_IDLE);
      end
      odt_active   <= odt_s && (dev_state != dcb_pkg::DV_SELF);
      in_self_ref  <= (dev_state == dcb_pkg::DV_SELF);
    end
  end

endmodule
`default_nettype wire

// ==== common/dcb_pkg.sv ====
/*
  dcb_pkg: shared types and constants for the command decoder and bank
  state tracker. Assumes a 100 MHz sys_clk; timing figures are plain
  defaults, not taken from any speed grade.
*/
package dcb_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int BA_W      = 3;
  localparam int ADDR_W    = 14;
  localparam int A10_BIT   = 10;
  localparam int CNT_W     = 8;

  // ---------------------------------------------------------------
  // timing, in ns, and derived cycle counts at 100 MHz
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RP_NS   = 15;
  localparam int T_RCD_NS  = 15;
  localparam int T_RFC_NS  = 128;
  localparam int T_MRD_NS  = 20;
  localparam int T_XSNR_NS = 138;
  localparam int T_BURST_NS = 20;
  localparam int T_WR_NS   = 15;

  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] RP_CYC    = CNT_W'(cyc_up(T_RP_NS));
  localparam logic [CNT_W-1:0] RCD_CYC   = CNT_W'(cyc_up(T_RCD_NS));
  localparam logic [CNT_W-1:0] RFC_CYC   = CNT_W'(cyc_up(T_RFC_NS));
  localparam logic [CNT_W-1:0] MRD_CYC   = CNT_W'(cyc_up(T_MRD_NS));
  localparam logic [CNT_W-1:0] XSNR_CYC  = CNT_W'(cyc_up(T_XSNR_NS));
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(cyc_up(T_BURST_NS));
  localparam logic [CNT_W-1:0] WR_CYC    = CNT_W'(cyc_up(T_WR_NS));

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_CKE = 1'b0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_DESEL   = 4'h0,
    CMD_NOP     = 4'h1,
    CMD_LMODE   = 4'h2,
    CMD_REF     = 4'h3,
    CMD_SR_IN   = 4'h4,
    CMD_SR_OUT  = 4'h5,
    CMD_PD_IN   = 4'h6,
    CMD_PD_OUT  = 4'h7,
    CMD_ACT     = 4'h8,
    CMD_RD      = 4'h9,
    CMD_WR      = 4'ha,
    CMD_PRE     = 4'hb,
    CMD_PRE_ALL = 4'hc,
    CMD_ILLEGAL = 4'hf
  } dcb_cmd_e;

  typedef enum logic [3:0] {
    BK_IDLE     = 4'h0,
    BK_ACTVG    = 4'h1,
    BK_ACTIVE   = 4'h2,
    BK_READ     = 4'h3,
    BK_WRITE    = 4'h4,
    BK_RD_AP    = 4'h5,
    BK_WR_AP    = 4'h6,
    BK_PRECHG   = 4'h7
  } dcb_bank_e;

  typedef enum logic [2:0] {
    DV_NORMAL = 3'h0,
    DV_REFRESH = 3'h1,
    DV_MODE   = 3'h2,
    DV_SELF   = 3'h3,
    DV_PDOWN  = 3'h4,
    DV_XSNR   = 3'h5
  } dcb_dev_e;

  // command pins as sampled
  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } dcb_pins_s;

  // decoded command as reported
  typedef struct packed {
    logic              valid;
    dcb_cmd_e          cmd;
    logic [BA_W-1:0]   bank;
    logic              auto_pre;
    logic [ADDR_W-1:0] addr;
  } dcb_dec_s;

endpackage

// ==== design/dcb_bank.sv ====
/*
  dcb_bank: one bank's state machine with its timing counter.
  Assumes commands already decoded and qualified by the top level.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_bank (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              hit,
  input  wire dcb_pkg::dcb_cmd_e cmd,
  input  wire logic              auto_pre,
  input  wire logic              force_idle,
  output var  dcb_pkg::dcb_bank_e state,
  output var  logic              rd_busy
);

  // ---------------------------------------------------------------
  // state and timer
  // ---------------------------------------------------------------
  logic [dcb_pkg::CNT_W-1:0] cnt;
  logic [dcb_pkg::CNT_W-1:0] rd_cnt;

  // read burst tail tracking, gates read-to-write
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_cnt <= '0;
    end else if (hit && cmd == dcb_pkg::CMD_RD) begin
      rd_cnt <= dcb_pkg::BURST_CYC;
    end else if (rd_cnt != '0) begin
      rd_cnt <= rd_cnt - 1'b1;
    end
  end
  assign rd_busy = (rd_cnt != '0);

  // bank transitions; timed states count down then move on
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= dcb_pkg::BK_IDLE;
      cnt   <= '0;
    end else if (force_idle) begin
      state <= dcb_pkg::BK_IDLE;
      cnt   <= '0;
    end else if (hit) begin
      case (cmd)
        dcb_pkg::CMD_ACT: begin
          state <= dcb_pkg::BK_ACTVG;
          cnt   <= dcb_pkg::RCD_CYC;
        end
        dcb_pkg::CMD_PRE, dcb_pkg::CMD_PRE_ALL: begin
          state <= dcb_pkg::BK_PRECHG;
          cnt   <= dcb_pkg::RP_CYC;
        end
        dcb_pkg::CMD_RD: begin
          state <= auto_pre ? dcb_pkg::BK_RD_AP : dcb_pkg::BK_READ;
          cnt   <= auto_pre ? dcb_pkg::BURST_CYC + dcb_pkg::RP_CYC
                            : dcb_pkg::BURST_CYC;
        end
        dcb_pkg::CMD_WR: begin
          state <= auto_pre ? dcb_pkg::BK_WR_AP : dcb_pkg::BK_WRITE;
          cnt   <= auto_pre ? dcb_pkg::BURST_CYC + dcb_pkg::WR_CYC
                              + dcb_pkg::RP_CYC
                            : dcb_pkg::BURST_CYC;
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 1'b1;
    end else if (cnt == 8'h01) begin
      cnt <= '0;
      case (state)
        dcb_pkg::BK_ACTVG, dcb_pkg::BK_READ, dcb_pkg::BK_WRITE:
          state <= dcb_pkg::BK_ACTIVE;
        dcb_pkg::BK_PRECHG, dcb_pkg::BK_RD_AP, dcb_pkg::BK_WR_AP:
          state <= dcb_pkg::BK_IDLE;
        default:
          state <= state;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dcb_top_props.sv ====
/*
  dcb_top_props: port-level assertions for dcb_top.
  Assumes it is bound into dcb_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_top_props #(
  parameter bit LARGE_DENSITY = 1'h1
) (
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire dcb_pkg::dcb_pins_s pins,
  input wire logic               odt,
  input wire dcb_pkg::dcb_dec_s  dec,
  input wire logic               cmd_illegal,
  input wire logic [7:0]         bank_idle,
  input wire dcb_pkg::dcb_dev_e  dev_state,
  input wire logic               odt_active,
  input wire logic               in_self_ref
);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // reported bank; small parts drop the top bit
  logic [2:0] ba_m;
  logic [3:0] pat;
  logic       hh;
  assign ba_m = LARGE_DENSITY ? pins.ba : {1'h0, pins.ba[1:0]};
  assign pat  = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

  // cke high now and one edge back
  always_ff @(posedge sys_clk) begin
    hh <= pins.cke;
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  property p_quiet;
    pins.cke && hh && (pins.cs_n || pat == 4'h7)
      |-> ##3 !dec.valid && !cmd_illegal;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("nop or deselect produced a command");

  property p_act;
    pins.cke && hh && pat == 4'h3 |-> ##3 cmd_illegal ||
      (dec.valid && dec.cmd == dcb_pkg::CMD_ACT &&
       dec.bank == $past(ba_m, 3) && dec.addr == $past(pins.addr, 3));
  endproperty
  a_act: assert property (p_act)
    else $error("activate decoded wrongly");

  property p_rw;
    pins.cke && hh && pat[3:1] == 3'h2 |-> ##3 cmd_illegal ||
      (dec.valid && dec.bank == $past(ba_m, 3) &&
       dec.auto_pre == $past(pins.addr[10], 3) &&
       dec.cmd == ($past(pins.we_n, 3) ? dcb_pkg::CMD_RD : dcb_pkg::CMD_WR));
  endproperty
  a_rw: assert property (p_rw)
    else $error("read or write decoded wrongly");

  property p_act_busy;
    dec.valid && dec.cmd == dcb_pkg::CMD_ACT
      |=> !bank_idle[$past(dec.bank)];
  endproperty
  a_act_busy: assert property (p_act_busy)
    else $error("activated bank still idle");

  property p_all_idle;
    dec.valid && dec.cmd inside {dcb_pkg::CMD_REF, dcb_pkg::CMD_LMODE}
      |-> $past(bank_idle) == 8'hff;
  endproperty
  a_all_idle: assert property (p_all_idle)
    else $error("refresh or mode load with a bank busy");

  property p_blocked;
    dec.valid |-> !($past(dev_state) inside
      {dcb_pkg::DV_REFRESH, dcb_pkg::DV_MODE});
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("command taken during refresh or mode load");

  property p_pall;
    dec.valid && dec.cmd == dcb_pkg::CMD_PRE_ALL |-> ##[1:6] &bank_idle;
  endproperty
  a_pall: assert property (p_pall)
    else $error("precharge all left a bank busy");

  property p_sr_in;
    hh && !pins.cke && pat == 4'h1 && &bank_idle &&
      dev_state == dcb_pkg::DV_NORMAL |-> ##[2:5] in_self_ref;
  endproperty
  a_sr_in: assert property (p_sr_in)
    else $error("self refresh not entered");

  property p_odt;
    in_self_ref |-> !odt_active;
  endproperty
  a_odt: assert property (p_odt)
    else $error("termination active in self refresh");

  property p_rfc;
    $rose(dev_state == dcb_pkg::DV_REFRESH) |->
      (dev_state == dcb_pkg::DV_REFRESH)[*8] ##1
      (dev_state == dcb_pkg::DV_REFRESH)[*5] ##1
      dev_state == dcb_pkg::DV_NORMAL;
  endproperty
  a_rfc: assert property (p_rfc)
    else $error("refresh period wrong");
endmodule

bind dcb_top dcb_top_props #(.LARGE_DENSITY(LARGE_DENSITY)) u_props (
  .sys_clk, .sys_rst, .pins, .odt, .dec, .cmd_illegal, .bank_idle,
  .dev_state, .odt_active, .in_self_ref);
`default_nettype wire

// ==== testbench/dcb_ctl_model.sv ====
/*
  dcb_ctl_model: controller stand-in driving the command pins.
  Assumes send is called once per cycle, just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dcb_ctl_model (
  input  wire logic               sys_clk,
  output var  dcb_pkg::dcb_pins_s pins
);
  // ----------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------
  // power up as a nop with cke low
  initial pins = {1'h0, 4'h7, 3'h0, 14'h0};

  // unused lines toggle so a stale value never looks valid
  task automatic send(
    input dcb_pkg::dcb_cmd_e c,
    input logic [2:0]        ba,
    input logic              a10,
    input logic              cke = 1'h1
  );
    dcb_pkg::dcb_pins_s p;
    logic [3:0]         pat;
    p = pins;
    p.ba = ~p.ba;
    p.addr = ~p.addr;
    case (c)
      dcb_pkg::CMD_DESEL: pat = 4'hf;
      dcb_pkg::CMD_LMODE: pat = 4'h0;
      dcb_pkg::CMD_REF, dcb_pkg::CMD_SR_IN: pat = 4'h1;
      dcb_pkg::CMD_ACT: pat = 4'h3;
      dcb_pkg::CMD_RD: pat = 4'h5;
      dcb_pkg::CMD_WR: pat = 4'h4;
      dcb_pkg::CMD_PRE, dcb_pkg::CMD_PRE_ALL: pat = 4'h2;
      default: pat = 4'h7;
    endcase
    if (pat != 4'h7 && pat != 4'hf) begin
      p.ba = ba;
      p.addr[10] = a10;
    end
    p.cke = cke;
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = pat;
    @(posedge sys_clk);
    pins <= p;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_ddr2_command_decode_bank_fsm.sv ====
/*
  test_ddr2_command_decode_bank_fsm: self-checking bench for dcb_top.
  Assumes dcb_ctl_model drives the pins and the checker is bound in.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ddr2_command_decode_bank_fsm;
  logic               sys_clk;
  logic               sys_rst;
  logic               odt;
  logic               cmd_illegal;
  logic               odt_active;
  logic               in_self_ref;
  logic [7:0]         bank_idle;
  dcb_pkg::dcb_pins_s pins;
  dcb_pkg::dcb_dec_s  dec;
  dcb_pkg::dcb_dev_e  dev_state;
  int                 err_total;
  int                 checks_done;

  dcb_ctl_model ctl (.sys_clk, .pins);
  dcb_top dut (.sys_clk, .sys_rst, .pins, .odt, .dec, .cmd_illegal,
    .bank_idle, .dev_state, .odt_active, .in_self_ref);

  // ----------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic nops(input int n, input logic cke = 1'h1);
    repeat (n) ctl.send(dcb_pkg::CMD_NOP, 3'h0, 1'h0, cke);
  endtask

  // decode shows at the third edge after the pins change
  task automatic run(input dcb_pkg::dcb_cmd_e c, input logic [2:0] ba,
                     input logic a10, input logic ill);
    ctl.send(c, ba, a10);
    nops(3);
    #1;
    chk("valid", !ill, dec.valid);
    chk("illegal", ill, cmd_illegal);
    if (!ill) begin
      chk("cmd", c, dec.cmd);
      if (!(c inside {dcb_pkg::CMD_REF, dcb_pkg::CMD_PRE_ALL}))
        chk("bank", ba, dec.bank);
      if (c inside {dcb_pkg::CMD_RD, dcb_pkg::CMD_WR})
        chk("auto_pre", a10, dec.auto_pre);
    end
  endtask

  // bounded wait for normal state with the masked banks idle
  task automatic wait_ok(input logic [7:0] m, input int lim);
    int i;
    #1;
    for (i = 0; i < lim; i++) begin
      if (dev_state === dcb_pkg::DV_NORMAL && (bank_idle & m) === m) break;
      nops(1);
      #1;
    end
    chk("dev", dcb_pkg::DV_NORMAL, dev_state);
    chk("idle", m, bank_idle & m);
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    #1;
    chk("dec", 1'h0, dec);
    chk("illegal", 1'h0, cmd_illegal);
    chk("idle", 8'hff, bank_idle);
    chk("dev", dcb_pkg::DV_NORMAL, dev_state);
    chk("odt", 1'h0, odt_active);
    chk("self_ref", 1'h0, in_self_ref);
    @(posedge sys_clk);
    sys_rst <= 1'h0;
    nops(6);
    repeat (4) begin
      ctl.send(dcb_pkg::CMD_DESEL, 3'h0, 1'h0);
      #1;
      chk("valid", 1'h0, dec.valid);
    end
    $display("test reset done");
  endtask

  task automatic t_act_rd;
    run(dcb_pkg::CMD_ACT, 3'h5, 1'h0, 1'h0);
    nops(1); // bank_idle lags dec by a cycle
    #1;
    chk("busy", 1'h0, bank_idle[5]);
    run(dcb_pkg::CMD_RD, 3'h2, 1'h1, 1'h1);
    run(dcb_pkg::CMD_RD, 3'h5, 1'h1, 1'h0);
    chk("busy", 1'h0, bank_idle[5]);
    wait_ok(8'h20, 12);
    $display("test act_rd done");
  endtask

  task automatic t_wr_pre;
    ctl.send(dcb_pkg::CMD_ACT, 3'h2, 1'h0);
    ctl.send(dcb_pkg::CMD_ACT, 3'h6, 1'h0);
    nops(4);
    #1;
    chk("idle", 8'hbb, bank_idle);
    run(dcb_pkg::CMD_WR, 3'h2, 1'h0, 1'h0);
    run(dcb_pkg::CMD_RD, 3'h2, 1'h0, 1'h0);
    nops(4);
    run(dcb_pkg::CMD_PRE, 3'h2, 1'h0, 1'h0);
    wait_ok(8'h04, 8);
    chk("busy", 1'h0, bank_idle[6]);
    run(dcb_pkg::CMD_PRE_ALL, 3'h3, 1'h1, 1'h0);
    wait_ok(8'hff, 8);
    $display("test wr_pre done");
  endtask

  task automatic t_ref_mode;
    ctl.send(dcb_pkg::CMD_REF, 3'h0, 1'h0);
    nops(1);
    ctl.send(dcb_pkg::CMD_ACT, 3'h1, 1'h0);
    nops(1);
    #1;
    chk("cmd", dcb_pkg::CMD_REF, dec.cmd);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("illegal", 1'h1, cmd_illegal);
    chk("dev", dcb_pkg::DV_REFRESH, dev_state);
    wait_ok(8'hff, 20);
    run(dcb_pkg::CMD_LMODE, 3'h2, 1'h0, 1'h0);
    nops(2);
    run(dcb_pkg::CMD_ACT, 3'h1, 1'h0, 1'h0);
    run(dcb_pkg::CMD_PRE, 3'h1, 1'h0, 1'h0);
    wait_ok(8'hff, 8);
    $display("test ref_mode done");
  endtask

  task automatic t_self_pd;
    @(posedge sys_clk);
    odt <= 1'h1;
    nops(4);
    #1;
    chk("odt", 1'h1, odt_active);
    ctl.send(dcb_pkg::CMD_SR_IN, 3'h0, 1'h0, 1'h0);
    nops(5, 1'h0);
    #1;
    chk("self_ref", 1'h1, in_self_ref);
    chk("odt", 1'h0, odt_active);
    ctl.send(dcb_pkg::CMD_DESEL, 3'h0, 1'h0, 1'h1);
    wait_ok(8'hff, 30);
    chk("self_ref", 1'h0, in_self_ref);
    run(dcb_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0);
    nops(5, 1'h0);
    #1;
    chk("dev", dcb_pkg::DV_PDOWN, dev_state);
    wait_ok(8'hfe, 10);
    run(dcb_pkg::CMD_PRE, 3'h0, 1'h0, 1'h0);
    $display("test self_pd done");
  endtask

  // ----------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    sys_rst = 1'h1;
    odt = 1'h0;
    repeat (5) @(posedge sys_clk);
    t_reset;
    t_act_rd;
    t_wr_pre;
    t_ref_mode;
    t_self_pd;
    end_of_test;
  end

  // tests need under 2 us; a hang is cut at twenty times that
  initial begin
    #40000;
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
